//--- eclc_params.svh
// Purpose: constants for the encoder counter latch control block
// Assumes: 8-bit control/status bytes, 32-bit counter
// Notes: bit positions within the control and status bytes
`ifndef ECLC_PARAMS_SVH
`define ECLC_PARAMS_SVH
`define ECLC_CB_REG_MODE 7
`define ECLC_CB_CLR_ON_LATCH 5
`define ECLC_CB_FALL_EN 4
`define ECLC_CB_RISE_EN 3
`define ECLC_CB_PRESET 2
`define ECLC_CB_READOUT 1
`define ECLC_CB_INDEX_EN 0
`define ECLC_SB_REG_MODE 7
`define ECLC_SB_GATE 4
`define ECLC_SB_INDEX 3
`define ECLC_SB_PRESET_ACK 2
`define ECLC_SB_READOUT 1
`define ECLC_SB_VALID 0
`define ECLC_CNT_W 32
`define ECLC_BYTE_W 8
`define ECLC_CNT_RST 32'h0000_0000
`endif

//--- eclc_pkg.sv
// Purpose: types for the encoder counter latch control block
// Assumes: eclc_params.svh holds the numbers
// Notes: capture source encoding
package eclc_pkg;
  typedef enum logic [1:0] {
    ECLC_SRC_NONE = 2'b00,
    ECLC_SRC_RISE = 2'b01,
    ECLC_SRC_FALL = 2'b10,
    ECLC_SRC_INDEX = 2'b11
  } eclc_src_t;
endpackage

//--- eclc_sync.sv
// Purpose: two-flop synchroniser with edge pulses from the second stage
// Assumes: async input, clock_i domain
// Notes: first stage feeds only the second stage
`timescale 1ns/1ns
module eclc_sync (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Pin
  input wire logic pin_i,
  // Outputs
  output logic level_o,
  output logic rise_o,
  output logic fall_o
);
  logic meta_r, sync_r, prev_r;
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      meta_r <= pin_i;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end
  assign level_o = sync_r;
  assign rise_o = sync_r & ~prev_r;
  assign fall_o = ~sync_r & prev_r;
endmodule // eclc_sync

//--- eclc_top.sv
// Purpose: control/status byte logic for one channel of a 32-bit encoder counter
// Assumes: process image bytes and words from same-clock logic; latch/index/gate are pins
// Notes: quadrature decoding outside; count steps arrive as up/down pulses
// Overview of operation
// - Register-mode bit zero selects process data mode with counter controls.
// - With clear-on-latch set, an active latch edge zeroes the counter.
// - Falling-capture enable captures the counter on the first falling latch edge only.
// - Rising-capture enable captures on the first rising edge and outranks falling.
// - A rising edge of preset request loads the counter from the output data.
// - Readout select chooses live count or latch for the input data.
// - Index-capture enable captures on the first rising index edge only.
// - The status byte carries mode, gate, index, preset ack, readout and valid.
// - Index capture valid sets on the index capture and holds until enable clears.
// - Preset acknowledge rises once the preset value is in the counter.
// - Readout-select status echoes which value is mapped to the input data.
`timescale 1ns/1ns
`include "eclc_params.svh"
module eclc_top import eclc_pkg::*; (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Process image from host
  input wire logic [`ECLC_BYTE_W-1:0] channel_control_byte_i,
  input wire logic [`ECLC_CNT_W-1:0] data_out_i,
  // Count steps from decoder
  input wire logic count_up_i,
  input wire logic count_down_i,
  // Pins
  input wire logic latch_pin_i,
  input wire logic index_pin_i,
  input wire logic gate_pin_i,
  // Process image to host
  output logic [`ECLC_BYTE_W-1:0] channel_status_byte_o,
  output logic [`ECLC_CNT_W-1:0] data_in_o,
  output logic [1:0] capture_source_o
);
  logic rst_m_r, rst_s_r;
  logic rst_n;
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_m_r <= 1'b0;
      rst_s_r <= 1'b0;
    end else begin
      rst_m_r <= 1'b1;
      rst_s_r <= rst_m_r;
    end
  end
  assign rst_n = rst_s_r;

  logic latch_lvl, latch_rise, latch_fall;
  logic index_lvl, index_rise, index_fall;
  logic gate_lvl;
  eclc_sync u_latch (
    .clock_i(clock_i), .rst_n_i(rst_n), .pin_i(latch_pin_i),
    .level_o(latch_lvl), .rise_o(latch_rise), .fall_o(latch_fall)
  );
  eclc_sync u_index (
    .clock_i(clock_i), .rst_n_i(rst_n), .pin_i(index_pin_i),
    .level_o(index_lvl), .rise_o(index_rise), .fall_o(index_fall)
  );
  eclc_sync u_gate (
    .clock_i(clock_i), .rst_n_i(rst_n), .pin_i(gate_pin_i),
    .level_o(gate_lvl), .rise_o(), .fall_o()
  );

  // Control fields; bit 6 is reserved and never read
  logic pd_mode, clr_en, fall_en, rise_en, preset_req, readout_sel, index_en;

  // Every counter control reads as zero while register mode is selected
  function automatic logic pd_bit(input logic [`ECLC_BYTE_W-1:0] cb, input int pos);
    return ~cb[`ECLC_CB_REG_MODE] & cb[pos];
  endfunction

  // Count step; simultaneous up and down pulses cancel
  function automatic logic [`ECLC_CNT_W-1:0] step_count(
    input logic [`ECLC_CNT_W-1:0] cnt,
    input logic up,
    input logic down
  );
    logic [`ECLC_CNT_W-1:0] res;
    res = cnt;
    // No saturation: both ends wrap
    if (up && !down) begin
      res = cnt + 32'h0000_0001;
    end else if (down && !up) begin
      res = cnt - 32'h0000_0001;
    end
    return res;
  endfunction

  assign pd_mode = ~channel_control_byte_i[`ECLC_CB_REG_MODE];
  assign clr_en = pd_bit(channel_control_byte_i, `ECLC_CB_CLR_ON_LATCH);
  assign fall_en = pd_bit(channel_control_byte_i, `ECLC_CB_FALL_EN);
  assign rise_en = pd_bit(channel_control_byte_i, `ECLC_CB_RISE_EN);
  assign preset_req = pd_bit(channel_control_byte_i, `ECLC_CB_PRESET);
  assign readout_sel = pd_bit(channel_control_byte_i, `ECLC_CB_READOUT);
  assign index_en = pd_bit(channel_control_byte_i, `ECLC_CB_INDEX_EN);

  logic [`ECLC_CNT_W-1:0] count_r, count_nxt;
  logic [`ECLC_CNT_W-1:0] latch_r, latch_nxt;
  logic edge_done_r, edge_done_nxt;
  logic index_done_r, index_done_nxt;
  logic valid_r, valid_nxt;
  logic preset_prev_r, preset_prev_nxt;
  logic preset_ack_r, preset_ack_nxt;
  eclc_src_t src_r, src_nxt;
  logic [`ECLC_BYTE_W-1:0] status_r, status_nxt;
  logic [`ECLC_CNT_W-1:0] data_in_r, data_in_nxt;

  logic rise_hit, fall_hit, edge_hit, index_hit;
  logic clear_hit, preset_rise;

  // Capture group: one-shot latch copies and their arming flags
  always_comb begin
    // Rising enable outranks falling when both set
    rise_hit = rise_en & ~edge_done_r & latch_rise;
    fall_hit = fall_en & ~rise_en & ~edge_done_r & latch_fall;
    edge_hit = rise_hit | fall_hit;
    index_hit = index_en & ~index_done_r & index_rise;
    latch_nxt = latch_r;
    src_nxt = src_r;
    if (index_hit) begin
      latch_nxt = count_r;
      src_nxt = ECLC_SRC_INDEX;
    end else if (edge_hit) begin
      latch_nxt = count_r;
      src_nxt = rise_hit ? ECLC_SRC_RISE : ECLC_SRC_FALL;
    end
    // Armed state drops when the enable is withdrawn
    edge_done_nxt = (rise_en | fall_en) & (edge_done_r | edge_hit);
    index_done_nxt = index_en & (index_done_r | index_hit);
    valid_nxt = index_en & (valid_r | index_hit);
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      latch_r <= `ECLC_CNT_RST;
      edge_done_r <= 1'b0;
      index_done_r <= 1'b0;
      valid_r <= 1'b0;
      src_r <= ECLC_SRC_NONE;
    end else begin
      latch_r <= latch_nxt;
      edge_done_r <= edge_done_nxt;
      index_done_r <= index_done_nxt;
      valid_r <= valid_nxt;
      src_r <= src_nxt;
    end
  end

  // Preset group: load only on a fresh request, so a held bit cannot reload
  always_comb begin
    preset_rise = preset_req & ~preset_prev_r;
    preset_prev_nxt = preset_req;
    preset_ack_nxt = preset_ack_r;
    if (preset_rise) begin
      preset_ack_nxt = 1'b1;
    end else if (!preset_req) begin
      preset_ack_nxt = 1'b0;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      preset_prev_r <= 1'b0;
      preset_ack_r <= 1'b0;
    end else begin
      preset_prev_r <= preset_prev_nxt;
      preset_ack_r <= preset_ack_nxt;
    end
  end

  // Counter group; preset wins over clear, it is the host's explicit value
  always_comb begin
    // Clear follows every enabled edge, even after the latch has been taken
    clear_hit = clr_en & ((rise_en & latch_rise) | (fall_en & ~rise_en & latch_fall) |
      (index_en & index_rise));
    count_nxt = step_count(count_r, count_up_i, count_down_i);
    if (clear_hit) begin
      count_nxt = `ECLC_CNT_RST;
    end
    if (preset_rise) begin
      count_nxt = data_out_i;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= `ECLC_CNT_RST;
    end else begin
      count_r <= count_nxt;
    end
  end

  // Output group: the host sees next-state values one edge after the cause
  always_comb begin
    // Reserved bits 6 and 5 stay zero
    status_nxt = '0;
    status_nxt[`ECLC_SB_REG_MODE] = ~pd_mode;
    status_nxt[`ECLC_SB_GATE] = gate_lvl;
    status_nxt[`ECLC_SB_INDEX] = index_lvl;
    status_nxt[`ECLC_SB_PRESET_ACK] = preset_ack_nxt;
    status_nxt[`ECLC_SB_READOUT] = readout_sel;
    status_nxt[`ECLC_SB_VALID] = valid_nxt;
    data_in_nxt = readout_sel ? latch_nxt : count_nxt;
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      status_r <= 8'h00;
      data_in_r <= `ECLC_CNT_RST;
    end else begin
      status_r <= status_nxt;
      data_in_r <= data_in_nxt;
    end
  end

  assign channel_status_byte_o = status_r;
  assign data_in_o = data_in_r;
  assign capture_source_o = src_r;
  // index_fall, latch_lvl unused by design; edges taken from synchroniser
  logic unused_ok;
  assign unused_ok = index_fall | latch_lvl;
endmodule // eclc_top

//--- eclc_coupler.sv
// Purpose: coupler model relaying the host output image
// Assumes: same clock as the device
// Notes: one exchange per clock; reserved bit sent as 0
`timescale 1ns/1ns
module eclc_coupler #(
  // Two-channel variant has no latch or index pins
  parameter bit TWO_CHANNEL = 1'b0
) (
  // Clock
  input wire logic clock_i,
  // Host image
  input wire logic [7:0] host_ctrl_i,
  input wire logic [31:0] host_data_i,
  // Device side
  output logic [7:0] ctrl_o = 8'h00,
  output logic [31:0] data_o = 32'h0000_0000
);
  always @(posedge clock_i) begin
    // Reserved bit always zero; latch and index controls too on the two-channel variant
    ctrl_o <= host_ctrl_i & (TWO_CHANNEL ? 8'h86 : 8'hbf);
    data_o <= host_data_i;
  end
endmodule // eclc_coupler

//--- eclc_checker.sv
// Purpose: port assertions for the latch control block
// Assumes: one clock, async active-low reset
// Notes: outputs lag their cause by one edge
`timescale 1ns/1ns
module eclc_checker (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Inputs
  input wire logic [7:0] channel_control_byte_i,
  input wire logic [31:0] data_out_i,
  input wire logic count_up_i,
  input wire logic count_down_i,
  // Outputs
  input wire logic [7:0] channel_status_byte_o,
  input wire logic [31:0] data_in_o,
  input wire logic [1:0] capture_source_o
);
  logic [7:0] cb;
  logic [7:0] sb;
  assign cb = channel_control_byte_i;
  assign sb = channel_status_byte_o;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  a_reserved_zero: assert property (sb[6:5] == 2'h0)
    else $error("reserved status set");
  a_mode_ack: assert property (sb[7] == $past(cb[7]))
    else $error("mode ack wrong");
  a_readout_echo: assert property (sb[1] == ($past(cb[1]) && !$past(cb[7])))
    else $error("readout echo wrong");
  a_preset_load: assert property (($rose(cb[2]) && !cb[7] && !cb[1]) |=>
    data_in_o == $past(data_out_i)) else $error("preset not loaded");
  a_ack_rise: assert property (($rose(cb[2]) && !cb[7]) |=> sb[2])
    else $error("preset ack missing");
  a_valid_drop: assert property ((!cb[0] || cb[7]) |=> !sb[0])
    else $error("valid held");
  a_valid_source: assert property ($rose(sb[0]) |-> capture_source_o == 2'h3)
    else $error("capture source wrong");
  a_count_step: assert property ((cb == 8'h00 ##1
    (cb == 8'h00 && (count_up_i ^ count_down_i))) |=>
    data_in_o == $past(data_in_o) + ($past(count_up_i) ? 32'h1 : 32'hffff_ffff))
    else $error("count step wrong");
endmodule // eclc_checker
bind eclc_top eclc_checker u_chk (.clock_i, .rst_n_i, .channel_control_byte_i, .data_out_i,
  .count_up_i, .count_down_i, .channel_status_byte_o, .data_in_o, .capture_source_o);

//--- tb_top.sv
// Purpose: self-checking bench for the latch control block
// Assumes: coupler model relays the host control byte
// Notes: pins pass a synchroniser, so waits are generous
`timescale 1ns/1ns
`define CHK(w, e, s) begin check_count++; if ((s) !== (e)) begin failures++; \
  $display("MISMATCH %s exp %h got %h", w, e, s); end end
module tb_top;
  logic clock_i = 0, rst_n_i = 0, up = 0, dn = 0, lat = 0, idx = 0, gate = 0;
  logic [7:0] c = 0, ctrl, sb;
  logic [31:0] hd = 0, dout, din, m = 0, ml = 0;
  logic [1:0] src;
  logic [1:0] sk [4] = '{2'h3, 2'h1, 2'h2, 2'h1};
  logic [7:0] ck [4] = '{8'h01, 8'h18, 8'h10, 8'h28};
  int failures = 0, check_count = 0;
  always #20 clock_i = ~clock_i;
  eclc_coupler u_cpl (.clock_i(clock_i), .host_ctrl_i(c), .host_data_i(hd), .ctrl_o(ctrl),
    .data_o(dout));
  eclc_top DUT (.clock_i(clock_i), .rst_n_i(rst_n_i), .channel_control_byte_i(ctrl),
    .data_out_i(dout), .count_up_i(up), .count_down_i(dn), .latch_pin_i(lat),
    .index_pin_i(idx), .gate_pin_i(gate), .channel_status_byte_o(sb), .data_in_o(din),
    .capture_source_o(src));
  task automatic tick(int n);
    repeat (n) @(posedge clock_i);
    #2;
  endtask
  task automatic setc(logic [7:0] x);
    c = x;
    tick(4);
  endtask
  task automatic step(bit u);
    up = u;
    dn = !u;
    m = u ? m + 32'h1 : m - 32'h1;
    tick(1);
    up = 0;
    dn = 0;
    tick(2);
  endtask
  task automatic chkd();
    `CHK("data_in", c[1] ? ml : m, din)
  endtask
  task automatic close_out();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    failures++;
    close_out();
  end
  initial begin
    void'($urandom(32'h8b65));
    tick(8);
    rst_n_i = 1;
    tick(4);
    chkd();
    hd = $urandom;
    setc(8'h04);
    m = hd;
    chkd();
    `CHK("ack", 1'b1, sb[2])
    setc(8'h00);
    `CHK("ack", 1'b0, sb[2])
    repeat ($urandom_range(12, 4)) step($urandom_range(1, 0));
    chkd();
    hd = 32'hffff_ffff;
    setc(8'h04);
    m = hd;
    setc(8'h00);
    step(1);
    chkd();
    for (int k = 0; k < 4; k++) begin
      lat = (k == 2);
      step(1);
      setc(ck[k]);
      if (k == 0) idx = 1;
      else lat = (k != 2);
      tick(6);
      ml = m;
      if (ck[k][5]) m = 0;
      `CHK("source", sk[k], src)
      `CHK("index", k == 0, sb[3])
      `CHK("valid", k == 0, sb[0])
      step(1);
      idx = 0;
      lat = !lat;
      tick(6);
      idx = (k == 0);
      lat = !lat;
      if (ck[k][5] && lat == ck[k][3]) m = 0;
      tick(6);
      setc(ck[k] | 8'h02);
      chkd();
      `CHK("readout", 1'b1, sb[1])
      setc(8'h00);
      chkd();
      `CHK("valid", 1'b0, sb[0])
      idx = 0;
      lat = 0;
      tick(6);
    end
    hd = $urandom;
    setc(8'h86);
    `CHK("status", 8'h80, sb)
    `CHK("data_in", m, din)
    setc(8'h00);
    gate = 1;
    tick(6);
    `CHK("status", 8'h10, sb)
    close_out();
  end
endmodule // tb_top
